/* File: hdl/aif_filter.sv */
// Integrating input filter for a group of signals sharing one tick
`timescale 1ns/1ns
`default_nettype none
module aif_filter #(
	parameter int WIDTH = 10
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Step enable from the delay divider
	input wire logic tick,
	// Signals
	input wire logic [WIDTH-1:0] sig_in,
	input wire logic [WIDTH-1:0] enable,
	output logic [WIDTH-1:0] sig_out
);
	localparam logic [aif_pkg::FILT_CNT_W-1:0] FULL = '1;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_sig
			logic [aif_pkg::FILT_CNT_W-1:0] cnt_ff;

			// Integrator: counts toward the input level on each tick
			always_ff @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
					cnt_ff <= '0;
				else if (!enable[i])
					cnt_ff <= sig_in[i] ? FULL : '0; // Parked so enabling causes no glitch
				else if (tick && sig_in[i] && cnt_ff != FULL)
					cnt_ff <= cnt_ff + 1'b1; // R21
				else if (tick && !sig_in[i] && cnt_ff != '0)
					cnt_ff <= cnt_ff - 1'b1; // R21
			end

			// Output moves one tick after saturation, so a change takes eight ticks
			// and a pulse of seven ticks or less never gets through
			always_ff @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
					sig_out[i] <= 1'b1; // Inputs idle high
				else if (!enable[i])
					sig_out[i] <= sig_in[i]; // R4
				else if (tick && cnt_ff == FULL && sig_in[i])
					sig_out[i] <= 1'b1; // R2 R3 R21
				else if (tick && cnt_ff == '0 && !sig_in[i])
					sig_out[i] <= 1'b0; // R2 R3 R21
			end
		end
	endgenerate
endmodule : aif_filter
`default_nettype wire

/* File: hdl/aif_pkg.sv */
// Shared constants for the axis input filter and external drive block
package aif_pkg;
	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int NUM_AXES = 4;
	localparam int AXIS_SIGS = 10;
	localparam int GLOBAL_SIGS = 2;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;

	// ----------------------------------------------------------------
	// Register addresses
	// ----------------------------------------------------------------
	localparam logic [3:0] ADDR_COMMAND = 4'h0;
	localparam logic [3:0] ADDR_EXT_STAGE = 4'h1;
	localparam logic [3:0] ADDR_MODE3_BASE = 4'h4;
	localparam logic [3:0] ADDR_STATUS_BASE = 4'h8;
	localparam logic [3:0] ADDR_EXT_ACTIVE_BASE = 4'hc;

	// ----------------------------------------------------------------
	// Field positions and codes
	// ----------------------------------------------------------------
	localparam int DELAY_SEL_MSB = 15;
	localparam int DELAY_SEL_LSB = 13;
	localparam int FE_MSB = 12;
	localparam int FE_LSB = 8;
	localparam int FE_EMG_BIT = 8;
	localparam int FE_SHARED_PULSE_BIT = 11;
	localparam int EXT_MODE_MSB = 4;
	localparam int EXT_MODE_LSB = 3;
	localparam int CMD_CODE_MSB = 7;
	localparam int CMD_AXIS_LSB = 8;
	localparam logic [7:0] CMD_SET_EXTENSION = 8'h60;
	localparam logic [15:0] EXT_RESET = 16'h0000;
	localparam logic [15:0] MODE3_RESET = 16'h0000;

	// External drive mode encodings
	localparam logic [1:0] EXT_FIXED = 2'b10;
	localparam logic [1:0] EXT_CONT = 2'b01;
	localparam logic [1:0] EXT_PULSER = 2'b11;

	// ----------------------------------------------------------------
	// Filter timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int FILT_STEPS = 8;
	localparam int FILT_CNT_W = 3;
	localparam int DELAY_CODE0_NS = 2000;
	localparam int DELAY_CODE1_NS = 256000;
	localparam int TICK0_CYCLES = DELAY_CODE0_NS / FILT_STEPS / CLK_PERIOD_NS;
	localparam int TICK1_CYCLES = DELAY_CODE1_NS / FILT_STEPS / CLK_PERIOD_NS;
	localparam int NUM_CODES = 8;
endpackage : aif_pkg

/* File: hdl/aif_top.sv */
// Four-axis input filtering and external drive triggering
// ----------------------------------------------------------------
// How it works
// R1: Bits 15..13 of extension word pick one of eight filter delays.
// R2: Delay 2 us at code 0, 256 us at code 1, doubling to 16.384 ms.
// R3: Rejected noise width is seven eighths of the delay at each code.
// R4: Five group enable bits, 8..12: one filters, zero passes through.
// R5: Bit8 stop/limits/in0/in1, bit9 in2, bit10 inpos/alarm, bit11 ext, bit12 in3.
// R6: Emergency stop and shared pulse enables come from axis zero only.
// R7: Reset clears every extension bit, so all filters pass through.
// R8: Extension settings take effect on selected axes when command 60h issues.
// R9: Every axis has its own identical filter with its own settings.
// R10: Mode3 bits 4..3: 10 fixed, 01 continuous, 11 pulser, else inert.
// R11: Outside party idles drive inputs high and presets parameters first.
// R12: Fixed mode: falling plus starts plus drive, falling minus starts minus.
// R13: Outside party holds a trigger low for more than four clocks.
// R14: Fixed mode ignores new falling edges while its drive still runs.
// R15: Continuous mode: falling edge starts drive that lasts while input low.
// R16: Release stops: decelerating if trapezoidal, sudden if constant speed.
// R17: Pulser mode: phase B low at phase A edge starts a minus drive.
// R18: Pulser mode outputs P pulses on each rising and falling A edge.
// R19: Host sets speed at least 2*F*P and initial speed equal to it.
// R20: Pulser mode: phase B high at phase A edge starts a plus drive.
// R21: Each filter is an up/down integrator whose output moves on saturation.
// ----------------------------------------------------------------
//
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module aif_top #(
	parameter int TICK0_CYCLES = aif_pkg::TICK0_CYCLES,
	parameter int TICK1_CYCLES = aif_pkg::TICK1_CYCLES
) (
	// Clock and reset
	input wire logic CORE_CLK,
	input wire logic RESET_N,
	// Register port
	input wire logic [aif_pkg::ADDR_W-1:0] REG_ADDR,
	input wire logic [aif_pkg::DATA_W-1:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [aif_pkg::DATA_W-1:0] REG_RDATA,
	// Raw chip-wide inputs, active low
	input wire logic EMG_STOP_N,
	input wire logic SHARED_EXT_PULSE_N,
	// Raw per-axis inputs, active low, one bit per axis
	input wire logic [3:0] PLUS_LIMIT_N,
	input wire logic [3:0] MINUS_LIMIT_N,
	input wire logic [3:0] GEN_IN0_N,
	input wire logic [3:0] GEN_IN1_N,
	input wire logic [3:0] GEN_IN2_N,
	input wire logic [3:0] GEN_IN3_N,
	input wire logic [3:0] IN_POSITION_N,
	input wire logic [3:0] SERVO_ALARM_N,
	input wire logic [3:0] EXT_PLUS_N,
	input wire logic [3:0] EXT_MINUS_N,
	// Drive generator state per axis
	input wire logic [3:0] AXIS_BUSY,
	input wire logic [3:0] AXIS_TRAPEZOID,
	// Filtered inputs
	output logic EMG_STOP_FILT_N,
	output logic SHARED_EXT_PULSE_FILT_N,
	output logic [39:0] AXIS_FILT_N,
	// Drive requests per axis
	output logic [3:0] START_FIXED,
	output logic [3:0] START_CONT,
	output logic [3:0] DIR_MINUS,
	output logic [3:0] STOP_DECEL,
	output logic [3:0] STOP_SUDDEN
);
	localparam int NA = aif_pkg::NUM_AXES;
	localparam int NS = aif_pkg::AXIS_SIGS;
	localparam int T0W = $clog2(TICK0_CYCLES + 1);
	localparam int T1W = $clog2(TICK1_CYCLES + 1);
	localparam logic [T0W-1:0] T0_LAST = T0W'(TICK0_CYCLES - 1);
	localparam logic [T1W-1:0] T1_LAST = T1W'(TICK1_CYCLES - 1);

	// Expand five group enables onto the ten per-axis signals
	function automatic logic [9:0] group_map(input logic [4:0] fe);
		group_map = {fe[4], fe[3], fe[3], fe[2], fe[2], fe[1],
			fe[0], fe[0], fe[0], fe[0]}; // R5
	endfunction : group_map

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	logic rst_meta_ff;
	logic rst_n_ff;

	// Release through two flops; assertion stays asynchronous
	always_ff @(posedge CORE_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			rst_meta_ff <= 1'b0;
			rst_n_ff <= 1'b0;
		end
		else
		begin
			rst_meta_ff <= 1'b1;
			rst_n_ff <= rst_meta_ff;
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [15:0] ext_stage_ff;
	logic [15:0] ext_active_ff [NA];
	logic [15:0] mode3_ff [NA];
	logic [7:0] cmd_last_ff;
	logic cmd_ext_hit;

	assign cmd_ext_hit = REG_WR && REG_ADDR == aif_pkg::ADDR_COMMAND
		&& REG_WDATA[aif_pkg::CMD_CODE_MSB:0] == aif_pkg::CMD_SET_EXTENSION;

	// Staged extension word; shared by all axes until applied
	always_ff @(posedge CORE_CLK or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
			ext_stage_ff <= aif_pkg::EXT_RESET; // R7
		else if (REG_WR && REG_ADDR == aif_pkg::ADDR_EXT_STAGE)
			ext_stage_ff <= REG_WDATA;
	end

	// Last command code, kept for readback
	always_ff @(posedge CORE_CLK or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
			cmd_last_ff <= 8'h00;
		else if (REG_WR && REG_ADDR == aif_pkg::ADDR_COMMAND)
			cmd_last_ff <= REG_WDATA[aif_pkg::CMD_CODE_MSB:0];
	end

	genvar a;
	generate
		for (a = 0; a < NA; a++)
		begin : g_reg
			// Apply staged settings only to axes named in the command
			always_ff @(posedge CORE_CLK or negedge rst_n_ff)
			begin
				if (!rst_n_ff)
					ext_active_ff[a] <= aif_pkg::EXT_RESET; // R7
				else if (cmd_ext_hit && REG_WDATA[aif_pkg::CMD_AXIS_LSB + a])
					ext_active_ff[a] <= ext_stage_ff; // R8
			end

			// Per-axis mode word three
			always_ff @(posedge CORE_CLK or negedge rst_n_ff)
			begin
				if (!rst_n_ff)
					mode3_ff[a] <= aif_pkg::MODE3_RESET;
				else if (REG_WR && REG_ADDR == aif_pkg::ADDR_MODE3_BASE + 4'(a))
					mode3_ff[a] <= REG_WDATA;
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Delay tick divider
	// ----------------------------------------------------------------
	logic [T0W-1:0] div0_ff;
	logic [T1W-1:0] div1_ff;
	logic [5:0] dbl_ff;
	logic [7:0] tick;

	// Code 0 base rate
	always_ff @(posedge CORE_CLK or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
			div0_ff <= '0;
		else if (div0_ff == T0_LAST)
			div0_ff <= '0;
		else
			div0_ff <= div0_ff + 1'b1;
	end

	// Code 1 base rate, and a binary chain for the doublings
	always_ff @(posedge CORE_CLK or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
		begin
			div1_ff <= '0;
			dbl_ff <= '0;
		end
		else if (div1_ff == T1_LAST)
		begin
			div1_ff <= '0;
			dbl_ff <= dbl_ff + 1'b1;
		end
		else
			div1_ff <= div1_ff + 1'b1;
	end

	assign tick[0] = div0_ff == T0_LAST; // R2
	assign tick[1] = div1_ff == T1_LAST; // R2

	// Each further code halves the tick rate
	genvar k;
	generate
		for (k = 2; k < aif_pkg::NUM_CODES; k++)
		begin : g_tick
			assign tick[k] = tick[1] && (&dbl_ff[k-2:0]); // R2 R3
		end
	endgenerate

	// ----------------------------------------------------------------
	// Filters
	// ----------------------------------------------------------------
	logic [NS-1:0] filt [NA];

	generate
		for (a = 0; a < NA; a++)
		begin : g_filt
			logic [NS-1:0] raw;
			logic [2:0] code;

			assign raw = {GEN_IN3_N[a], EXT_MINUS_N[a], EXT_PLUS_N[a], SERVO_ALARM_N[a],
				IN_POSITION_N[a], GEN_IN2_N[a], GEN_IN1_N[a], GEN_IN0_N[a],
				MINUS_LIMIT_N[a], PLUS_LIMIT_N[a]};
			assign code = ext_active_ff[a][aif_pkg::DELAY_SEL_MSB:aif_pkg::DELAY_SEL_LSB];

			// Own delay and enables per axis
			aif_filter #(.WIDTH(NS)) u_filt ( // R9
				.clk(CORE_CLK),
				.rst_n(rst_n_ff),
				.tick(tick[code]), // R1
				.sig_in(raw),
				.enable(group_map(ext_active_ff[a][aif_pkg::FE_MSB:aif_pkg::FE_LSB])), // R4
				.sig_out(filt[a])
			);
			assign AXIS_FILT_N[a*NS +: NS] = filt[a];
		end
	endgenerate

	// Chip-wide inputs use the first axis's settings
	aif_filter #(.WIDTH(aif_pkg::GLOBAL_SIGS)) u_filt_global (
		.clk(CORE_CLK),
		.rst_n(rst_n_ff),
		.tick(tick[ext_active_ff[0][aif_pkg::DELAY_SEL_MSB:aif_pkg::DELAY_SEL_LSB]]),
		.sig_in({SHARED_EXT_PULSE_N, EMG_STOP_N}),
		.enable({ext_active_ff[0][aif_pkg::FE_SHARED_PULSE_BIT],
			ext_active_ff[0][aif_pkg::FE_EMG_BIT]}), // R6
		.sig_out({SHARED_EXT_PULSE_FILT_N, EMG_STOP_FILT_N})
	);

	// ----------------------------------------------------------------
	// External drive triggering
	// ----------------------------------------------------------------
	generate
		for (a = 0; a < NA; a++)
		begin : g_ext
			logic plus_prev_ff;
			logic minus_prev_ff;
			logic pending_ff;
			logic cont_on_ff;
			logic cont_minus_ff;
			logic [1:0] mode;
			logic plus_fall;
			logic minus_fall;
			logic a_edge;
			logic fixed_go;
			logic cont_go;
			logic cont_end;
			logic plus_lvl;
			logic minus_lvl;

			assign plus_lvl = filt[a][7];
			assign minus_lvl = filt[a][8];
			assign mode = mode3_ff[a][aif_pkg::EXT_MODE_MSB:aif_pkg::EXT_MODE_LSB]; // R10
			assign plus_fall = plus_prev_ff && !plus_lvl;
			assign minus_fall = minus_prev_ff && !minus_lvl;
			assign a_edge = plus_prev_ff != plus_lvl;
			// Busy can lag the start by a cycle, so the pending flag covers the gap
			assign fixed_go = mode == aif_pkg::EXT_FIXED && (plus_fall || minus_fall)
				&& !AXIS_BUSY[a] && !pending_ff; // R12 R14
			assign cont_go = mode == aif_pkg::EXT_CONT && !cont_on_ff
				&& (plus_fall || minus_fall); // R15
			assign cont_end = cont_on_ff
				&& (cont_minus_ff ? minus_lvl : plus_lvl); // R16

			// Edge history
			always_ff @(posedge CORE_CLK or negedge rst_n_ff)
			begin
				if (!rst_n_ff)
				begin
					plus_prev_ff <= 1'b1;
					minus_prev_ff <= 1'b1;
				end
				else
				begin
					plus_prev_ff <= plus_lvl;
					minus_prev_ff <= minus_lvl;
				end
			end

			// Fixed drive in flight until busy is seen
			always_ff @(posedge CORE_CLK or negedge rst_n_ff)
			begin
				if (!rst_n_ff)
					pending_ff <= 1'b0;
				else if (fixed_go)
					pending_ff <= 1'b1; // R14
				else if (AXIS_BUSY[a])
					pending_ff <= 1'b0;
			end

			// Continuous drive held while its input stays low
			always_ff @(posedge CORE_CLK or negedge rst_n_ff)
			begin
				if (!rst_n_ff)
				begin
					cont_on_ff <= 1'b0;
					cont_minus_ff <= 1'b0;
				end
				else if (cont_go)
				begin
					cont_on_ff <= 1'b1; // R15
					cont_minus_ff <= !plus_fall; // Plus wins a tie
				end
				else if (cont_end || mode != aif_pkg::EXT_CONT)
					cont_on_ff <= 1'b0;
			end

			// Start, stop and direction requests
			always_ff @(posedge CORE_CLK or negedge rst_n_ff)
			begin
				if (!rst_n_ff)
				begin
					START_FIXED[a] <= 1'b0;
					START_CONT[a] <= 1'b0;
					STOP_DECEL[a] <= 1'b0;
					STOP_SUDDEN[a] <= 1'b0;
					DIR_MINUS[a] <= 1'b0;
				end
				else
				begin
					START_FIXED[a] <= fixed_go
						|| (mode == aif_pkg::EXT_PULSER && a_edge); // R18
					START_CONT[a] <= cont_go;
					STOP_DECEL[a] <= cont_end && AXIS_TRAPEZOID[a]; // R16
					STOP_SUDDEN[a] <= cont_end && !AXIS_TRAPEZOID[a]; // R16
					if (mode == aif_pkg::EXT_PULSER && a_edge)
						DIR_MINUS[a] <= !minus_lvl; // R17 R20
					else if (fixed_go || cont_go)
						DIR_MINUS[a] <= !plus_fall; // R12
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Readback
	// ----------------------------------------------------------------
	logic [15:0] rd_mux;

	// Status words show filtered levels and the axis drive state
	always_comb
	begin
		rd_mux = 16'h0000;
		if (REG_ADDR == aif_pkg::ADDR_COMMAND)
			rd_mux = {8'h00, cmd_last_ff};
		else if (REG_ADDR == aif_pkg::ADDR_EXT_STAGE)
			rd_mux = ext_stage_ff;
		else if (REG_ADDR[3:2] == aif_pkg::ADDR_MODE3_BASE[3:2])
			rd_mux = mode3_ff[REG_ADDR[1:0]];
		else if (REG_ADDR[3:2] == aif_pkg::ADDR_STATUS_BASE[3:2])
			rd_mux = {AXIS_BUSY[REG_ADDR[1:0]], 2'b00, SHARED_EXT_PULSE_FILT_N,
				EMG_STOP_FILT_N, 1'b0, filt[REG_ADDR[1:0]]};
		else if (REG_ADDR[3:2] == aif_pkg::ADDR_EXT_ACTIVE_BASE[3:2])
			rd_mux = ext_active_ff[REG_ADDR[1:0]]; // Holes at 2 and 3 read zero
	end

	// Data stand only in the cycle after the read strobe
	always_ff @(posedge CORE_CLK or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
			REG_RDATA <= 16'h0000;
		else if (REG_RD)
			REG_RDATA <= rd_mux;
		else
			REG_RDATA <= 16'h0000;
	end
endmodule : aif_top
`default_nettype wire

/* File: verif/aif_far_side.sv */
// Far-side model: external drive sources and the drive generator busy flag
`timescale 1ns/1ns
`default_nettype none
module aif_far_side #(
	parameter int FIXED_LEN = 40
) (
	// Clock
	input wire logic clk,
	// Requests for axis zero
	input wire logic start_fixed,
	input wire logic start_cont,
	input wire logic stop_any,
	// Drive inputs and busy
	output logic plus_n,
	output logic minus_n,
	output logic busy
);
	int cnt = 0;

	// Idle level is high on both drive inputs
	initial
	begin
		plus_n = 1'b1;
		minus_n = 1'b1;
	end

	// Fixed drive runs a set span; continuous runs until stopped
	always @(posedge clk)
		if (start_fixed)
			cnt <= FIXED_LEN;
		else if (start_cont)
			cnt <= -1;
		else if (stop_any)
			cnt <= 0;
		else if (cnt > 0)
			cnt <= cnt - 1;
	assign busy = (cnt != 0);

	// Trigger held low well beyond four clocks
	task automatic trig(input logic minus, input int len);
	begin
		@(posedge clk);
		if (minus)
			minus_n <= 1'b0;
		else
			plus_n <= 1'b0;
		repeat (len) @(posedge clk);
		plus_n <= 1'b1;
		minus_n <= 1'b1;
	end
	endtask : trig

	// Encoder phases: A on the plus line, B on the minus line
	task automatic enc(input logic a, input logic b);
	begin
		@(posedge clk);
		plus_n <= a;
		minus_n <= b;
		// Edges spaced past the drive span, as a host sizing speed would ensure
		repeat (FIXED_LEN + 2) @(posedge clk);
	end
	endtask : enc
endmodule : aif_far_side
`default_nettype wire

/* File: verif/aif_top_checker.sv */
// Port-level properties for the input filter and external drive block
`timescale 1ns/1ns
`default_nettype none
module aif_top_checker (
	// Clock and reset
	input wire logic CORE_CLK,
	input wire logic RESET_N,
	// Register port
	input wire logic [3:0] REG_ADDR,
	input wire logic [15:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [15:0] REG_RDATA,
	// Axis state and requests
	input wire logic [39:0] AXIS_FILT_N,
	input wire logic [3:0] AXIS_BUSY,
	input wire logic [3:0] AXIS_TRAPEZOID,
	input wire logic [3:0] START_FIXED,
	input wire logic [3:0] START_CONT,
	input wire logic [3:0] DIR_MINUS,
	input wire logic [3:0] STOP_DECEL,
	input wire logic [3:0] STOP_SUDDEN
);
	logic [1:0] mode0_ff;

	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!RESET_N);

	// Mirror of the axis zero drive mode; the register itself is hidden
	always_ff @(posedge CORE_CLK or negedge RESET_N)
		if (!RESET_N)
			mode0_ff <= 2'b00;
		else if (REG_WR && REG_ADDR == 4'h4)
			mode0_ff <= REG_WDATA[4:3];

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	property p_rd_idle;
		!$past(REG_RD) |-> REG_RDATA == 16'h0000;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
	property p_inert;
		mode0_ff == 2'b00 |-> !START_FIXED[0] && !START_CONT[0];
	endproperty
	a_inert: assert property (p_inert) else $error("start with drive off");
	property p_fixed;
		mode0_ff == 2'b10 && ($fell(AXIS_FILT_N[7]) || $fell(AXIS_FILT_N[8]))
		&& !AXIS_BUSY[0] && !START_FIXED[0]
		|=> START_FIXED[0] && DIR_MINUS[0] == $past(AXIS_FILT_N[7]);
	endproperty
	a_fixed: assert property (p_fixed) else $error("fixed start missing");
	property p_busy;
		mode0_ff == 2'b10 && $past(AXIS_BUSY[0]) |-> !START_FIXED[0];
	endproperty
	a_busy: assert property (p_busy) else $error("start while busy");
	property p_cont_dir;
		START_CONT[0] |-> (DIR_MINUS[0] ? !AXIS_FILT_N[8] : !AXIS_FILT_N[7]);
	endproperty
	a_cont_dir: assert property (p_cont_dir) else $error("continuous dir wrong");
	property p_stop_kind;
		STOP_DECEL[0] || STOP_SUDDEN[0]
		|-> STOP_DECEL[0] == $past(AXIS_TRAPEZOID[0])
		&& STOP_SUDDEN[0] != $past(AXIS_TRAPEZOID[0]);
	endproperty
	a_stop_kind: assert property (p_stop_kind) else $error("stop kind wrong");
	property p_stop_rel;
		mode0_ff == 2'b01 && AXIS_BUSY[0] && $rose(AXIS_FILT_N[7]) && AXIS_FILT_N[8]
		|=> STOP_DECEL[0] || STOP_SUDDEN[0];
	endproperty
	a_stop_rel: assert property (p_stop_rel) else $error("no stop on release");
	property p_pulser;
		mode0_ff == 2'b11 && $changed(AXIS_FILT_N[7])
		|=> START_FIXED[0] && DIR_MINUS[0] == !$past(AXIS_FILT_N[8]);
	endproperty
	a_pulser: assert property (p_pulser) else $error("pulser step wrong");
endmodule : aif_top_checker

bind aif_top aif_top_checker aif_top_checker_inst (
	.CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .REG_ADDR(REG_ADDR),
	.REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
	.AXIS_FILT_N(AXIS_FILT_N), .AXIS_BUSY(AXIS_BUSY), .AXIS_TRAPEZOID(AXIS_TRAPEZOID),
	.START_FIXED(START_FIXED), .START_CONT(START_CONT), .DIR_MINUS(DIR_MINUS),
	.STOP_DECEL(STOP_DECEL), .STOP_SUDDEN(STOP_SUDDEN)
);
`default_nettype wire

/* File: verif/tb_aif_top.sv */
// Self-checking bench for the input filter and external drive block
`timescale 1ns/1ns
`default_nettype none
module tb_aif_top;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [15:0] wdata = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [3:0] inp_n = 4'hf;
	logic [3:0] trap = 4'h0;
	logic [15:0] rdata;
	logic emg_f;
	logic shp_f;
	logic [39:0] filt;
	logic [3:0] st_fx;
	logic [3:0] st_ct;
	logic [3:0] dir_m;
	logic [3:0] stp_d;
	logic [3:0] stp_s;
	logic plus_n;
	logic minus_n;
	logic busy;
	logic last_dir = 1'b0;
	int n_fx = 0;
	int n_ct = 0;
	int n_dec = 0;
	int n_sud = 0;
	int err_count = 0;
	int comparisons = 0;

	// Core clock, 10 ns period
	always #5 clk = ~clk;

	// Raw inputs but the external drive lines share one pattern so group routing shows in one sample
	aif_top #(.TICK0_CYCLES(2), .TICK1_CYCLES(4)) aif_top_inst (
		.CORE_CLK(clk), .RESET_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wdata),
		.REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
		.EMG_STOP_N(inp_n[0]), .SHARED_EXT_PULSE_N(inp_n[0]),
		.PLUS_LIMIT_N(inp_n), .MINUS_LIMIT_N(inp_n), .GEN_IN0_N(inp_n), .GEN_IN1_N(inp_n),
		.GEN_IN2_N(inp_n), .GEN_IN3_N(inp_n), .IN_POSITION_N(inp_n), .SERVO_ALARM_N(inp_n),
		.EXT_PLUS_N({3'h7, plus_n}), .EXT_MINUS_N({3'h7, minus_n}),
		.AXIS_BUSY({3'h0, busy}), .AXIS_TRAPEZOID(trap),
		.EMG_STOP_FILT_N(emg_f), .SHARED_EXT_PULSE_FILT_N(shp_f), .AXIS_FILT_N(filt),
		.START_FIXED(st_fx), .START_CONT(st_ct), .DIR_MINUS(dir_m),
		.STOP_DECEL(stp_d), .STOP_SUDDEN(stp_s)
	);

	aif_far_side aif_far_side_inst (
		.clk(clk), .start_fixed(st_fx[0]), .start_cont(st_ct[0]),
		.stop_any(stp_d[0] | stp_s[0]), .plus_n(plus_n), .minus_n(minus_n), .busy(busy)
	);

	// Tally axis zero requests so sequences compare totals
	always @(posedge clk)
	begin
		if (st_fx[0] || st_ct[0])
			last_dir <= dir_m[0];
		n_fx <= n_fx + int'(st_fx[0]);
		n_ct <= n_ct + int'(st_ct[0]);
		n_dec <= n_dec + int'(stp_d[0]);
		n_sud <= n_sud + int'(stp_s[0]);
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
	begin
		comparisons++;
		if (got !== exp)
		begin
			err_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc

	task automatic wrr(input logic [3:0] a, input logic [15:0] d);
	begin
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	end
	endtask : wrr

	// Data stand only in the cycle after the strobe
	task automatic rdc(input logic [3:0] a, input logic [15:0] exp);
	begin
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk("read", exp, rdata);
	end
	endtask : rdc

	// Pull every raw input but the external drive lines low and look two clocks later
	task automatic grp(input logic [9:0] e0, input logic [9:0] e1, input logic [9:0] e3,
		input logic e);
	begin
		@(posedge clk);
		inp_n <= 4'h0;
		cyc(2);
		#1;
		chk("axis0", {6'h00, e0}, {6'h00, filt[9:0]});
		chk("axis1", {6'h00, e1}, {6'h00, filt[19:10]});
		chk("axis2", {6'h00, e3}, {6'h00, filt[29:20]});
		chk("axis3", {6'h00, e3}, {6'h00, filt[39:30]});
		chk("chipwide", {14'h0000, e, e}, {14'h0000, emg_f, shp_f});
		@(posedge clk);
		inp_n <= 4'hf;
		cyc(120);
	end
	endtask : grp

	task automatic end_sim;
	begin
		$display("Comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	end
	endtask : end_sim

	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial
	begin
		int t;
		int lows;
		cyc(16);
		rst_n <= 1'b1;
		cyc(3);
		for (int a = 12; a < 16; a++)
			rdc(4'(a), 16'h0000);
		rdc(4'h8, 16'h1bff);
		grp(10'h180, 10'h180, 10'h180, 1'b0);
		wrr(4'h2, 16'hffff);
		rdc(4'h2, 16'h0000);
		wrr(4'h1, 16'h4900);
		rdc(4'hc, 16'h0000);
		wrr(4'h0, 16'h0360);
		rdc(4'hc, 16'h4900);
		rdc(4'hd, 16'h4900);
		rdc(4'he, 16'h0000);
		grp(10'h18f, 10'h18f, 10'h180, 1'b1);
		// A short glitch must never reach the filtered output
		@(posedge clk);
		inp_n <= 4'h0;
		cyc(3);
		inp_n <= 4'hf;
		lows = 0;
		repeat (100)
		begin
			@(posedge clk);
			lows += int'(!filt[2]);
		end
		chk("glitch", 16'h0000, 16'(lows));
		wrr(4'h1, 16'h0900);
		wrr(4'h0, 16'h0e60);
		rdc(4'h3, 16'h0000);
		wrr(4'h1, 16'h0000);
		wrr(4'h0, 16'h0160);
		grp(10'h180, 10'h18f, 10'h18f, 1'b0);
		// Delay doubles per code above code one
		for (int c = 0; c < 4; c++)
		begin
			t = (c == 0) ? 2 : (4 << (c - 1));
			wrr(4'h1, {3'(c), 13'h0100});
			wrr(4'h0, 16'h0160);
			@(posedge clk);
			inp_n <= 4'h0;
			cyc(5 * t);
			chk("delay early", 16'h0001, {15'h0000, filt[2]});
			cyc(3 * t + 4);
			chk("delay late", 16'h0000, {15'h0000, filt[2]});
			inp_n <= 4'hf;
			cyc(9 * t + 8);
		end
		aif_far_side_inst.trig(1'b0, 6);
		cyc(10);
		chk("inert", 16'h0000, 16'(n_fx + n_ct));
		wrr(4'h4, 16'h0010);
		aif_far_side_inst.trig(1'b0, 6);
		cyc(4);
		chk("fixed plus", 16'h0010, {8'h00, 4'(n_fx), 3'h0, last_dir});
		aif_far_side_inst.trig(1'b1, 6);
		cyc(4);
		chk("fixed busy", 16'h0001, 16'(n_fx));
		cyc(40);
		aif_far_side_inst.trig(1'b1, 6);
		cyc(4);
		chk("fixed minus", 16'h0021, {8'h00, 4'(n_fx), 3'h0, last_dir});
		cyc(44);
		wrr(4'h4, 16'h0008);
		trap <= 4'h1;
		aif_far_side_inst.trig(1'b0, 10);
		cyc(4);
		chk("cont plus", 16'h1100, {4'(n_ct), 4'(n_dec), 4'(n_sud), 3'h0, last_dir});
		trap <= 4'h0;
		aif_far_side_inst.trig(1'b1, 10);
		cyc(4);
		chk("cont minus", 16'h2111, {4'(n_ct), 4'(n_dec), 4'(n_sud), 3'h0, last_dir});
		wrr(4'h4, 16'h0018);
		rdc(4'h4, 16'h0018);
		aif_far_side_inst.enc(1'b0, 1'b1);
		cyc(6);
		aif_far_side_inst.enc(1'b1, 1'b1);
		cyc(6);
		chk("pulser plus", 16'h0040, {8'h00, 4'(n_fx), 3'h0, last_dir});
		aif_far_side_inst.enc(1'b1, 1'b0);
		cyc(6);
		aif_far_side_inst.enc(1'b0, 1'b0);
		cyc(6);
		aif_far_side_inst.enc(1'b1, 1'b0);
		cyc(6);
		chk("pulser minus", 16'h0061, {8'h00, 4'(n_fx), 3'h0, last_dir});
		aif_far_side_inst.enc(1'b1, 1'b1);
		cyc(6);
		end_sim();
	end

	// Whole run needs under two thousand cycles
	initial
	begin
		#200000;
		err_count++;
		end_sim();
	end
endmodule : tb_aif_top
`default_nettype wire
